// ===== core/tpc_params.svh
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define TPC_NUM_CH        8
`define TPC_CH_AW         3
`define TPC_CREG_W        12
`define TPC_GREG_W        8
`define TPC_IDX_W         10
`define TPC_OHM_W         10

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TPC_CHAN_IDX_LAST 10'h007
`define TPC_GLOBAL_IDX    10'h082
`define TPC_STATUS_IDX    10'h083

// ----------------------------------------------------------------------------
// Channel control register fields
// ----------------------------------------------------------------------------
`define TPC_F_RX_TERM     7
`define TPC_F_TX_TERM     6
`define TPC_F_IMP_LO      4
`define TPC_F_RES_LO      2
`define TPC_F_PAT_LO      8
`define TPC_F_TXEN        11

// ----------------------------------------------------------------------------
// Global handover register fields
// ----------------------------------------------------------------------------
`define TPC_G_TXON_HO     7
`define TPC_G_RXTERM_HO   6

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define TPC_CREG_RST      12'h000
`define TPC_GREG_RST      8'h00
`define TPC_RESP_OKAY     2'h0
`define TPC_RESP_SLVERR   2'h2
`define TPC_PSEL_PRBS     3'h4
`define TPC_PSEL_ONES     3'h5
`define TPC_PSEL_LUC      3'h6
`define TPC_PSEL_LDC      3'h7

`endif

// ===== core/tpc_pkg.sv
package tpc_pkg;
`include "tpc_params.svh"

  typedef enum logic [1:0] {TPC_RD_IDLE, TPC_RD_FETCH, TPC_RD_RESP} tpc_rd_state_t;
  typedef enum logic [2:0] {TPC_PAT_NONE, TPC_PAT_PRBS, TPC_PAT_ONES, TPC_PAT_LUC, TPC_PAT_LDC} tpc_pattern_t;

  typedef logic [`TPC_CREG_W-1:0]                   tpc_creg_t;
  typedef logic [`TPC_NUM_CH-1:0][`TPC_CREG_W-1:0]  tpc_creg_arr_t;
  typedef logic [`TPC_NUM_CH-1:0][1:0]              tpc_ch2_t;
  typedef logic [`TPC_NUM_CH-1:0][`TPC_OHM_W-1:0]   tpc_ohm_arr_t;

  typedef struct packed {
    tpc_creg_arr_t regs;
    tpc_creg_t     rdata;
  } tpc_mem_state_t;

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    aw_got;
    logic                    w_got;
    logic [`TPC_IDX_W-1:0]   waddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    tpc_rd_state_t           rd_st;
    logic [`TPC_IDX_W-1:0]   raddr;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [`TPC_GREG_W-1:0]  global_reg;
    logic [`TPC_NUM_CH-1:0]  rx_int;
    logic [`TPC_NUM_CH-1:0]  tx_int;
    tpc_ch2_t                imp;
    tpc_ch2_t                res;
    tpc_ohm_arr_t            rint;
    logic [`TPC_NUM_CH-1:0]  txen;
    logic [`TPC_NUM_CH-1:0]  prbs;
    logic [`TPC_NUM_CH-1:0]  ones;
    logic [`TPC_NUM_CH-1:0]  luc;
    logic [`TPC_NUM_CH-1:0]  ldc;
  } tpc_ctrl_state_t;

  function automatic tpc_pattern_t tpc_decode_pattern(input logic [2:0] sel);
    tpc_pattern_t p;
    p = TPC_PAT_NONE;
    if (sel == `TPC_PSEL_PRBS) p = TPC_PAT_PRBS;
    if (sel == `TPC_PSEL_ONES) p = TPC_PAT_ONES;
    if (sel == `TPC_PSEL_LUC)  p = TPC_PAT_LUC;
    if (sel == `TPC_PSEL_LDC)  p = TPC_PAT_LDC;
    return p;
  endfunction

  // Internal receive resistor in ohms; zero stands for an open circuit.
  function automatic logic [`TPC_OHM_W-1:0] tpc_rint_ohms(input logic [1:0] imp, input logic [1:0] res);
    logic [`TPC_OHM_W-1:0] r;
    r = 10'h000;
    case ({res, imp})
      4'h0: r = 10'h064;
      4'h1: r = 10'h06E;
      4'h2: r = 10'h04B;
      4'h3: r = 10'h078;
      4'h4: r = 10'h0AC;
      4'h5: r = 10'h0CC;
      4'h6: r = 10'h06C;
      4'h7: r = 10'h0F0;
      4'h8: r = 10'h0C0;
      4'h9: r = 10'h0E8;
      4'hA: r = 10'h074;
      4'hB: r = 10'h118;
      4'hC: r = 10'h12C;
      4'hD: r = 10'h19C;
      4'hE: r = 10'h096;
      default: r = 10'h258;
    endcase
    return r;
  endfunction

endpackage

// ===== core/tpc_chanmem.sv
`timescale 1ns/10ps
`include "tpc_params.svh"

module tpc_chanmem (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  input  wire logic                      we,
  input  wire logic [`TPC_CH_AW-1:0]     waddr,
  input  wire tpc_pkg::tpc_creg_t        wdata,
  input  wire tpc_pkg::tpc_creg_t        wmask,
  input  wire logic                      re,
  input  wire logic [`TPC_CH_AW-1:0]     raddr,
  output tpc_pkg::tpc_creg_t             rdata,
  output tpc_pkg::tpc_creg_arr_t         regs
);
  import tpc_pkg::*;

  tpc_mem_state_t m_q;
  tpc_mem_state_t m_d;

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // A read that meets a write to the same word returns the old contents.
  always_comb begin
    m_d = m_q;
    if (ce) begin
      if (we) begin
        m_d.regs[waddr] = (m_q.regs[waddr] & ~wmask) | (wdata & wmask);
      end
      if (re) begin
        m_d.rdata = m_q.regs[raddr];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rdata = m_q.rdata;
  assign regs  = m_q.regs;

endmodule

// ===== core/tpc_ctrl.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "tpc_params.svh"

// Operation
// - Host mode: channel bit 7 selects internal receive termination
// - Hardware mode: receive strap sets all receive terminations
// - Hardware mode: transmit strap sets all transmit terminations
// - Host mode: channel bit 6 selects internal transmit termination
// - Reset leaves every channel on external termination
// - Impedance codes give 100, 110, 75, 120 ohms
// - Resistor field pairs 240, 210 or 150 ohms
// - External transmit termination disables internal circuitry
// - Global bit 7 hands transmit enable to pins
// - Global bit 6 hands receive termination to pin
// - Inactive transmit enable tri-states the transmit outputs
// - Pattern field decodes none, random, ones, loop codes
// - Hardware mode: per-channel strap forces all-ones transmission
// - All-ones ignores transmit data, sends AMI ones
module tpc_ctrl (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic [11:0]                 awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [11:0]                 araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        host_mode_pin,
  input  wire logic                        rx_term_internal_sel,
  input  wire logic                        tx_term_internal_sel,
  input  wire logic [1:0]                  term_impedance_sel,
  input  wire logic [1:0]                  rx_ext_resistor_sel,
  input  wire logic [`TPC_NUM_CH-1:0]      tx_output_enable_pin,
  input  wire logic [`TPC_NUM_CH-1:0]      all_ones_strap_pin,
  output logic [`TPC_NUM_CH-1:0]           rx_term_internal,
  output logic [`TPC_NUM_CH-1:0]           tx_term_internal,
  output tpc_pkg::tpc_ch2_t                line_term_impedance,
  output tpc_pkg::tpc_ch2_t                line_rx_ext_resistor,
  output tpc_pkg::tpc_ohm_arr_t            rx_rint_ohms,
  output logic [`TPC_NUM_CH-1:0]           tx_driver_enable,
  output logic [`TPC_NUM_CH-1:0]           prbs_pattern,
  output logic [`TPC_NUM_CH-1:0]           all_ones_pattern,
  output logic [`TPC_NUM_CH-1:0]           loop_up_code_pattern,
  output logic [`TPC_NUM_CH-1:0]           loop_down_code_pattern
);
  import tpc_pkg::*;

  tpc_ctrl_state_t s_q;
  tpc_ctrl_state_t s_d;

  logic                    mem_we;
  logic                    mem_re;
  tpc_creg_t               mem_rdata;
  tpc_creg_arr_t           chan_regs;
  tpc_creg_t               mem_wmask;
  logic                    wr_fire;
  logic                    tx_ho;
  logic                    rx_ho;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic tpc_is_chan(input logic [`TPC_IDX_W-1:0] idx);
    return idx <= `TPC_CHAN_IDX_LAST;
  endfunction

  function automatic tpc_creg_t tpc_lane_mask(input logic [3:0] strb);
    tpc_creg_t m;
    m = {{4{strb[1]}}, {8{strb[0]}}};
    return m;
  endfunction

  // ----------------------------------------------------------------------------
  // Channel register store
  // ----------------------------------------------------------------------------
  assign wr_fire   = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign mem_we    = ce && wr_fire && tpc_is_chan(s_q.waddr);
  assign mem_re    = ce && s_q.arready && arvalid;
  assign mem_wmask = tpc_lane_mask(s_q.wstrb);
  assign tx_ho     = s_q.global_reg[`TPC_G_TXON_HO];
  assign rx_ho     = s_q.global_reg[`TPC_G_RXTERM_HO];

  tpc_chanmem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (s_q.waddr[`TPC_CH_AW-1:0]),
    .wdata   (s_q.wdata[`TPC_CREG_W-1:0]),
    .wmask   (mem_wmask),
    .re      (mem_re),
    .raddr   (araddr[`TPC_CH_AW+1:2]),
    .rdata   (mem_rdata),
    .regs    (chan_regs)
  );

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Hardware mode ignores the handover register: the straps and pins own every
  // selection, so software cannot override a board strap by accident.
  always_comb begin
    tpc_pattern_t pat;
    logic [2:0]   psel;
    pat  = TPC_PAT_NONE;
    psel = 3'h0;
    s_d  = s_q;
    if (ce) begin
      if (wr_fire) begin
        s_d.bvalid = 1'h1;
        s_d.aw_got = 1'h0;
        s_d.w_got  = 1'h0;
        s_d.bresp  = `TPC_RESP_OKAY;
        if (tpc_is_chan(s_q.waddr)) begin
          s_d.bresp = `TPC_RESP_OKAY;
        end else if (s_q.waddr == `TPC_GLOBAL_IDX) begin
          if (s_q.wstrb[0]) begin
            s_d.global_reg = s_q.wdata[`TPC_GREG_W-1:0];
          end
        end else begin
          s_d.bresp = `TPC_RESP_SLVERR;
        end
      end else if (s_q.bvalid && bready) begin
        s_d.bvalid = 1'h0;
      end
      if (s_q.awready && awvalid) begin
        s_d.aw_got = 1'h1;
        s_d.waddr  = awaddr[11:2];
      end
      if (s_q.wready && wvalid) begin
        s_d.w_got = 1'h1;
        s_d.wdata = wdata;
        s_d.wstrb = wstrb;
      end
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;

      unique case (s_q.rd_st)
        TPC_RD_IDLE: begin
          if (s_q.arready && arvalid) begin
            s_d.raddr = araddr[11:2];
            s_d.rd_st = TPC_RD_FETCH;
          end
        end
        TPC_RD_FETCH: begin
          s_d.rd_st  = TPC_RD_RESP;
          s_d.rvalid = 1'h1;
          s_d.rresp  = `TPC_RESP_OKAY;
          if (tpc_is_chan(s_q.raddr)) begin
            s_d.rdata = {20'h00000, mem_rdata};
          end else if (s_q.raddr == `TPC_GLOBAL_IDX) begin
            s_d.rdata = {24'h000000, s_q.global_reg};
          end else if (s_q.raddr == `TPC_STATUS_IDX) begin
            s_d.rdata = {s_q.ones, s_q.txen, s_q.tx_int, s_q.rx_int};
          end else begin
            s_d.rdata = 32'h00000000;
            s_d.rresp = `TPC_RESP_SLVERR;
          end
        end
        TPC_RD_RESP: begin
          if (rready) begin
            s_d.rvalid = 1'h0;
            s_d.rd_st  = TPC_RD_IDLE;
          end
        end
      endcase
      s_d.arready = (s_d.rd_st == TPC_RD_IDLE);

      for (int c = 0; c < `TPC_NUM_CH; c++) begin
        if (host_mode_pin) begin
          s_d.rx_int[c] = rx_ho ? rx_term_internal_sel : chan_regs[c][`TPC_F_RX_TERM];
          s_d.tx_int[c] = chan_regs[c][`TPC_F_TX_TERM];
          s_d.imp[c]    = chan_regs[c][`TPC_F_IMP_LO +: 2];
          s_d.res[c]    = chan_regs[c][`TPC_F_RES_LO +: 2];
          s_d.txen[c]   = tx_ho ? tx_output_enable_pin[c] : chan_regs[c][`TPC_F_TXEN];
          psel          = chan_regs[c][`TPC_F_PAT_LO +: 3];
        end else begin
          s_d.rx_int[c] = rx_term_internal_sel;
          s_d.tx_int[c] = tx_term_internal_sel;
          s_d.imp[c]    = term_impedance_sel;
          s_d.res[c]    = rx_ext_resistor_sel;
          s_d.txen[c]   = tx_output_enable_pin[c];
          psel          = all_ones_strap_pin[c] ? `TPC_PSEL_ONES : 3'h0;
        end
        // An open receive resistor reads as zero ohms on this port.
        s_d.rint[c] = s_d.rx_int[c] ? tpc_rint_ohms(s_d.imp[c], s_d.res[c]) : 10'h000;
        pat         = tpc_decode_pattern(psel);
        s_d.prbs[c] = (pat == TPC_PAT_PRBS);
        s_d.ones[c] = (pat == TPC_PAT_ONES);
        s_d.luc[c]  = (pat == TPC_PAT_LUC);
        s_d.ldc[c]  = (pat == TPC_PAT_LDC);
      end
    end
  end

  // Everything resets to zero: external termination, drivers off, no pattern.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign awready                = s_q.awready;
  assign wready                 = s_q.wready;
  assign bresp                  = s_q.bresp;
  assign bvalid                 = s_q.bvalid;
  assign arready                = s_q.arready;
  assign rdata                  = s_q.rdata;
  assign rresp                  = s_q.rresp;
  assign rvalid                 = s_q.rvalid;
  assign rx_term_internal       = s_q.rx_int;
  assign tx_term_internal       = s_q.tx_int;
  assign line_term_impedance    = s_q.imp;
  assign line_rx_ext_resistor   = s_q.res;
  assign rx_rint_ohms           = s_q.rint;
  assign tx_driver_enable       = s_q.txen;
  assign prbs_pattern           = s_q.prbs;
  assign all_ones_pattern       = s_q.ones;
  assign loop_up_code_pattern   = s_q.luc;
  assign loop_down_code_pattern = s_q.ldc;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_host_reg;
    ce && host_mode_pin && !rx_ho;
  endsequence

  sequence s_write_ready;
    ce && s_q.aw_got && s_q.w_got && !s_q.bvalid;
  endsequence

  property p_rx_host;
    s_host_reg |=> rx_term_internal[0] == $past(chan_regs[0][7]);
  endproperty
  a_rx_host: assert property (p_rx_host) else $error("rx termination ignores channel bit");

  property p_rx_hw;
    ce && !host_mode_pin |=> rx_term_internal == {8{$past(rx_term_internal_sel)}};
  endproperty
  a_rx_hw: assert property (p_rx_hw) else $error("rx strap not applied to all channels");

  property p_tx_hw;
    ce && !host_mode_pin |=> tx_term_internal == {8{$past(tx_term_internal_sel)}};
  endproperty
  a_tx_hw: assert property (p_tx_hw) else $error("tx strap not applied to all channels");

  property p_tx_host;
    ce && host_mode_pin |=> tx_term_internal[3] == $past(chan_regs[3][6]);
  endproperty
  a_tx_host: assert property (p_tx_host) else $error("tx termination ignores channel bit");

  property p_reset_ext;
    disable iff (1'h0) !aresetn |=> (rx_term_internal == 8'h00) && (tx_term_internal == 8'h00);
  endproperty
  a_reset_ext: assert property (p_reset_ext) else $error("termination not external after reset");

  property p_rint_e1;
    ce && !host_mode_pin && rx_term_internal_sel && term_impedance_sel == 2'h2 && rx_ext_resistor_sel == 2'h3
      |=> rx_rint_ohms[5] == 10'h096;
  endproperty
  a_rint_e1: assert property (p_rint_e1) else $error("wrong internal resistor for 150 ohm pairing");

  property p_rint_t1;
    ce && !host_mode_pin && rx_term_internal_sel && term_impedance_sel == 2'h0 && rx_ext_resistor_sel == 2'h0
      |=> rx_rint_ohms[2] == 10'h064;
  endproperty
  a_rint_t1: assert property (p_rint_t1) else $error("wrong internal resistor for 100 ohm");

  property p_txon_pin;
    ce && host_mode_pin && tx_ho |=> tx_driver_enable == $past(tx_output_enable_pin);
  endproperty
  a_txon_pin: assert property (p_txon_pin) else $error("transmit enable not taken from pins");

  property p_rxterm_pin;
    ce && host_mode_pin && rx_ho |=> rx_term_internal == {8{$past(rx_term_internal_sel)}};
  endproperty
  a_rxterm_pin: assert property (p_rxterm_pin) else $error("rx termination not taken from pin");

  property p_tx_off;
    ce && host_mode_pin && !tx_ho && !chan_regs[1][11] |=> !tx_driver_enable[1];
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("driver enabled while control inactive");

  property p_pattern_luc;
    ce && host_mode_pin && chan_regs[6][10:8] == 3'h6 |=> loop_up_code_pattern[6] && !all_ones_pattern[6];
  endproperty
  a_pattern_luc: assert property (p_pattern_luc) else $error("loop-up pattern not decoded");

  property p_ones_hw;
    ce && !host_mode_pin && all_ones_strap_pin[6] |=> all_ones_pattern[6] && !prbs_pattern[6];
  endproperty
  a_ones_hw: assert property (p_ones_hw) else $error("all-ones strap not honoured");

  property p_hold;
    !mem_we |=> $stable(chan_regs);
  endproperty
  a_hold: assert property (p_hold) else $error("channel register changed without a write");

  property p_write_resp;
    s_write_ready |=> bvalid && !awready && !wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response not raised");

endmodule

// ===== tb/tpc_board_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Board straps and transmit-on pins
// ----------------------------------------------------------------------------
// Straps are soldered levels, so the model only lets them change on a clock edge.
// Glitching them between edges would hide real timing faults.
module tpc_board_model (
  input  wire logic        aclk,
  input  wire logic [22:0] cmd,
  output logic [22:0]      pins
);
  always_ff @(posedge aclk) begin
    pins <= cmd;
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tpc_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              ce = 1'b1;
  logic [11:0]       awaddr = 12'h000;
  logic [11:0]       araddr = 12'h000;
  logic [31:0]       wdata = 32'h0000_0000;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [22:0]       cmd, pins;
  logic [7:0]        rx_ti, tx_ti, txen, prbs, ones, luc, ldc;
  tpc_ch2_t          imp, res;
  tpc_ohm_arr_t      rint;
  logic [33:0]       exp_q [$];
  logic [33:0]       rd_exp;
  logic [31:0]       cv [8];
  logic [9:0]        ohm [16] = '{10'h064, 10'h06E, 10'h04B, 10'h078, 10'h0AC, 10'h0CC, 10'h06C, 10'h0F0,
                                  10'h0C0, 10'h0E8, 10'h074, 10'h118, 10'h12C, 10'h19C, 10'h096, 10'h258};
  logic [7:0]        r, rxv, txv;
  int                fail_count = 0, total_checks = 0, cyc = 0;

  always #10 aclk = ~aclk;

  tpc_board_model board (.aclk(aclk), .cmd(cmd), .pins(pins));

  tpc_ctrl uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .host_mode_pin(pins[22]), .rx_term_internal_sel(pins[21]),
    .tx_term_internal_sel(pins[20]), .term_impedance_sel(pins[19:18]), .rx_ext_resistor_sel(pins[17:16]),
    .tx_output_enable_pin(pins[15:8]), .all_ones_strap_pin(pins[7:0]), .rx_term_internal(rx_ti),
    .tx_term_internal(tx_ti), .line_term_impedance(imp), .line_rx_ext_resistor(res), .rx_rint_ohms(rint),
    .tx_driver_enable(txen), .prbs_pattern(prbs), .all_ones_pattern(ones), .loop_up_code_pattern(luc),
    .loop_down_code_pattern(ldc)
  );

  // ----------------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this only cuts a hang.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  always @(posedge aclk) begin
    if (rvalid && rready) begin
      rd_exp = exp_q.pop_front();
      chk(rdata, rd_exp[31:0]);
      chk({30'h0, rresp}, {30'h0, rd_exp[33:32]});
    end
  end

  // ----------------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------------
  // Each task lets one edge pass at its end, so that a following call never
  // assigns the same handshake signal twice in one time step.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    exp_q.push_back({er, e});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    cmd = 23'h400000;
    void'($urandom(96277));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk({rx_ti, tx_ti, txen}, 24'h000000);
    axi_rd(12'h20C, 32'h0000_0000);
    $display("test reset done");
    // Every pattern code lands on one channel; the all-ones pins stay low throughout host mode.
    for (int c = 0; c < 8; c++) begin
      cv[c] = {20'h00000, 1'b1, 3'(c), 8'($urandom)};
      rxv[c] = cv[c][7];
      txv[c] = cv[c][6];
      axi_wr(12'(c * 4), cv[c], 2'h0);
      axi_rd(12'(c * 4), cv[c]);
    end
    settle();
    for (int c = 0; c < 8; c++) begin
      chk({rint[c], imp[c], res[c], rx_ti[c], tx_ti[c]}, {(cv[c][7] ? ohm[{cv[c][3:2], cv[c][5:4]}] : 10'h000),
          cv[c][5:4], cv[c][3:2], cv[c][7], cv[c][6]});
    end
    chk({ldc, luc, ones, prbs}, 32'h80402010);
    axi_rd(12'h20C, {8'h20, 8'hFF, txv, rxv});
    $display("test host channels done");
    r = 8'($urandom);
    cmd <= {3'b110, 4'h0, r, 8'h00};
    settle();
    chk({rx_ti, txen}, {rxv, 8'hFF});
    axi_wr(12'h208, 32'h0000_00C0, 2'h0);
    axi_rd(12'h208, 32'h0000_00C0);
    settle();
    chk({rx_ti, txen}, {8'hFF, r});
    // Swap order for a backup card: receivers go external before the primary is released.
    cmd <= {3'b100, 4'h0, r, 8'h00};
    settle();
    chk(rx_ti, 8'h00);
    axi_wr(12'h208, 32'h0000_0000, 2'h0);
    settle();
    chk({rx_ti, txen}, {rxv, 8'hFF});
    $display("test handover done");
    axi_wr(12'h400, 32'hFFFF_FFFF, 2'h2);
    axi_wr(12'h20C, 32'hFFFF_FFFF, 2'h2);
    axi_rd(12'h400, 32'h0000_0000, 2'h2);
    axi_rd(12'h000, cv[0]);
    $display("test refused access done");
    // Protection setup: transmitters internal, the backup driver off, then a failed card goes quiet.
    axi_wr(12'h000, 32'h0000_0040, 2'h0);
    axi_wr(12'h004, 32'h0000_0840, 2'h0);
    settle();
    chk({tx_ti[1:0], txen[1:0]}, 4'hE);
    axi_wr(12'h004, 32'h0000_0040, 2'h0);
    settle();
    chk({tx_ti[1], txen[1]}, 2'h2);
    $display("test protection done");
    r = 8'($urandom) | 8'h40;
    cmd <= {3'b001, 4'hC, 8'hFF, r};
    settle();
    chk({tx_ti, rx_ti, ones}, {8'hFF, 8'h00, r});
    cmd <= {3'b010, 4'hB, 8'h0F, r};
    settle();
    chk({tx_ti, rx_ti, txen}, {8'h00, 8'hFF, 8'h0F});
    chk({22'h0, rint[3]}, {22'h0, ohm[14]});
    // With the clock enable low the new straps must not reach the outputs.
    ce <= 1'b0;
    cmd <= {3'b010, 4'h0, 8'h0F, r};
    settle();
    chk({22'h0, rint[2]}, {22'h0, ohm[14]});
    ce <= 1'b1;
    settle();
    chk({22'h0, rint[2]}, {22'h0, ohm[0]});
    $display("test hardware mode done");
    test_done();
  end
endmodule
